// ### design/ttmc_pkg.sv
/*
  Shared constants and types of the task trigger and mode controller:
  register offsets, field positions, reset values, codes and timing.
  Assumes a 100 MHz pclk and a 32-bit APB register bus.
*/
package ttmc_pkg;

  // ==========================================================
  // Sizes and ranges
  localparam int NSLOT = 16;
  localparam int NALL = 17;
  localparam logic [5:0] NUM_MIN = 6'h18;
  localparam logic [5:0] NUM_MAX = 6'h27;
  localparam logic [2:0] PRIO_MIN = 3'h2;
  localparam logic [2:0] PRIO_MAX = 3'h7;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_SEL = 8'h08;
  localparam logic [7:0] A_CFG = 8'h0C;
  localparam logic [7:0] A_SRC = 8'h10;
  localparam logic [7:0] A_HSC = 8'h14;
  localparam logic [7:0] A_PEND = 8'h18;

  // ==========================================================
  // Field positions
  localparam int F_EN = 0;
  localparam int F_PRIO = 1;
  localparam int F_NUM = 4;
  localparam int F_WORD = 10;
  localparam int F_COND = 11;
  localparam int F_CH = 10;
  localparam int S_REFUSED = 4;
  localparam int S_CFG_ERR = 5;
  localparam int S_PROG_ERR = 6;
  localparam int S_BUSY = 7;

  // ==========================================================
  // Codes and reset values
  localparam logic [2:0] C_RISE = 3'h0;
  localparam logic [2:0] C_FALL = 3'h1;
  localparam logic [2:0] C_TRANS = 3'h2;
  localparam logic [2:0] C_ON = 3'h3;
  localparam logic [2:0] C_OFF = 3'h4;
  localparam logic [2:0] C_LT = 3'h0;
  localparam logic [2:0] C_LE = 3'h1;
  localparam logic [2:0] C_EQ = 3'h2;
  localparam logic [2:0] C_GE = 3'h3;
  localparam logic [2:0] C_GT = 3'h4;
  localparam logic [1:0] CMD_RUN = 2'h1;
  localparam logic [1:0] CMD_STOP = 2'h2;
  localparam logic [1:0] CMD_DBG = 2'h3;
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_RUN = 2'h1;
  localparam logic [1:0] MODE_DBG = 2'h2;
  localparam logic [2:0] PRIO_RST = 3'h7;
  localparam logic [5:0] NUM_RST = 6'h00;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int HSC_POLL_US = 250;
  localparam int HSC_POLL_CYC = HSC_POLL_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_STOP_ENT, ST_STOP, ST_RUN_ENT, ST_RUN, ST_DBG_ENT, ST_DBG
  } ttmc_mode_t;

  typedef enum logic [1:0] {W_IDLE, W_SRC, W_WAIT, W_EVAL} ttmc_walk_t;

endpackage : ttmc_pkg

// ### design/ttmc_sync.sv
/*
  Two-flop synchroniser for asynchronous pin levels.
  Assumes the input is a slow level such as a panel switch.
*/
`timescale 1ns/1ps
module ttmc_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce) begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule : ttmc_sync

// ### design/ttmc_mem.sv
/*
  Small memory holding the watched address and compare word of each
  trigger slot. One write port, one read port, registered read data.
  Assumes writes and reads come from the same clock domain.
*/
`timescale 1ns/1ps
module ttmc_mem #(
  parameter int DW = 32,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rdata_ff;

  always_ff @(posedge pclk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= '0;
    end else if (ce && re) begin
      rdata_ff <= mem[raddr];
    end
  end

  assign rdata = rdata_ff;
endmodule : ttmc_mem

// ### design/ttmc_top.sv
/*
  Task trigger and operating mode controller: end-of-scan checks of
  internal-device trigger slots, counter-match task polling, task
  request arbitration and the RUN/STOP/DEBUG mode sequencer.
  Assumes an APB master, a scan executor on pclk that answers a device
  word read one cycle after dev_addr, and a panel switch on a pin.
*/
`timescale 1ns/1ps
module ttmc_top #(
  parameter int NCH = 2,
  parameter int HSC_POLL = ttmc_pkg::HSC_POLL_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sw_run_pin,
  input wire logic prog_valid,
  input wire logic scan_end,
  input wire logic dbg_prog_end,
  output logic [11:0] dev_addr,
  input wire logic [15:0] dev_rdata,
  input wire logic [NCH*32-1:0] hsc_count,
  input wire logic [NCH*32-1:0] hsc_cmp0,
  output logic task_req_valid,
  output logic [5:0] task_req_num,
  output logic [2:0] task_req_prio,
  input wire logic task_ready,
  input wire logic task_done,
  input wire logic [5:0] task_done_num,
  output logic [1:0] mode,
  output logic data_init,
  output logic out_clear,
  output logic out_refresh,
  output logic in_refresh,
  output logic exec_en,
  output logic debug_en,
  output logic svc_en
);
  import ttmc_pkg::*;

  localparam int PW = $clog2(HSC_POLL + 1);
  localparam logic [PW-1:0] POLL_LAST = PW'(HSC_POLL - 1);

  // ==========================================================
  // Mode switch pin
  logic sw_s;
  logic sw_d_ff;
  logic sw_rise;
  logic sw_fall;

  ttmc_sync #(.W(1)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(sw_run_pin),
    .q(sw_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_d_ff <= 1'b0;
    end else if (ce) begin
      sw_d_ff <= sw_s;
    end
  end

  assign sw_rise = sw_s & ~sw_d_ff;
  assign sw_fall = ~sw_s & sw_d_ff;

  // ==========================================================
  // APB slave
  function automatic logic f_mapped(input logic [7:0] a);
    return a inside {A_CTRL, A_STAT, A_SEL, A_CFG, A_SRC, A_HSC, A_PEND};
  endfunction : f_mapped

  logic wr;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_cfg;
  logic wr_src;
  logic [31:0] rd_val;
  logic [31:0] prdata_ff;

  assign wr = psel & penable & pwrite & ce;
  assign wr_ctrl = wr & (paddr == A_CTRL);
  assign wr_stat = wr & (paddr == A_STAT);
  assign wr_cfg = wr & (paddr == A_CFG);
  assign wr_src = wr & (paddr == A_SRC);
  // Frozen clock enable also stalls the bus, so no write is lost
  assign pready = ce;
  assign pslverr = psel & penable & ~f_mapped(paddr);
  assign prdata = prdata_ff;

  // ==========================================================
  // Configuration registers
  logic [3:0] sel_ff;
  logic [NSLOT-1:0] en_ff;
  logic [NSLOT-1:0] word_ff;
  logic [2:0] prio_ff [NSLOT];
  logic [5:0] num_ff [NSLOT];
  logic [2:0] cond_ff [NSLOT];
  logic hsc_en_ff;
  logic [2:0] hsc_prio_ff;
  logic [5:0] hsc_num_ff;
  logic [1:0] hsc_ch_ff;
  logic cfg_ok;
  logic [5:0] nw_num;
  logic [2:0] nw_prio;

  assign nw_num = pwdata[F_NUM +: 6];
  assign nw_prio = pwdata[F_PRIO +: 3];

  always_comb begin
    cfg_ok = (nw_prio >= PRIO_MIN) && (nw_prio <= PRIO_MAX)
      && (nw_num >= NUM_MIN) && (nw_num <= NUM_MAX);
    for (int i = 0; i < NSLOT; i++) begin
      if (i != int'(sel_ff) && en_ff[i] && num_ff[i] == nw_num) begin
        cfg_ok = 1'b0;
      end
    end
    // Disabling a slot is always allowed
    if (!pwdata[F_EN]) begin
      cfg_ok = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ff <= 4'h0;
      en_ff <= '0;
      word_ff <= '0;
      for (int i = 0; i < NSLOT; i++) begin
        prio_ff[i] <= PRIO_RST;
        num_ff[i] <= NUM_RST;
        cond_ff[i] <= C_RISE;
      end
    end else if (ce) begin
      if (wr & (paddr == A_SEL)) begin
        sel_ff <= pwdata[3:0];
      end
      if (wr_cfg && cfg_ok) begin
        en_ff[sel_ff] <= pwdata[F_EN];
        prio_ff[sel_ff] <= nw_prio;
        num_ff[sel_ff] <= nw_num;
        word_ff[sel_ff] <= pwdata[F_WORD];
        cond_ff[sel_ff] <= pwdata[F_COND +: 3];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hsc_en_ff <= 1'b0;
      hsc_prio_ff <= PRIO_RST;
      hsc_num_ff <= NUM_RST;
      hsc_ch_ff <= 2'h0;
    end else if (ce && wr && paddr == A_HSC) begin
      hsc_en_ff <= pwdata[F_EN];
      hsc_prio_ff <= pwdata[F_PRIO +: 3];
      hsc_num_ff <= pwdata[F_NUM +: 6];
      hsc_ch_ff <= pwdata[F_CH +: 2];
    end
  end

  // ==========================================================
  // Mode sequencer
  ttmc_mode_t state_ff;
  ttmc_mode_t nxt_state;
  logic remote_ff;
  logic nxt_remote;
  logic set_refused;
  logic set_prog_err;
  logic cmd_v;
  logic run;

  assign cmd_v = wr_ctrl & (pwdata[1:0] != 2'h0);
  assign run = (state_ff == ST_RUN);

  always_comb begin
    nxt_state = state_ff;
    nxt_remote = remote_ff;
    set_refused = 1'b0;
    set_prog_err = 1'b0;
    unique case (state_ff)
      ST_RUN_ENT: begin
        if (prog_valid) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_state = ST_STOP_ENT;
          nxt_remote = 1'b0;
          set_prog_err = 1'b1;
        end
        set_refused = cmd_v;
      end
      ST_STOP_ENT: begin
        nxt_state = ST_STOP;
        set_refused = cmd_v;
      end
      ST_DBG_ENT: begin
        nxt_state = ST_DBG;
        set_refused = cmd_v;
      end
      ST_STOP, ST_RUN, ST_DBG: begin
        if (sw_rise) begin
          nxt_state = ST_RUN_ENT;
          nxt_remote = 1'b0;
        end else if (sw_fall) begin
          nxt_state = ST_STOP_ENT;
          nxt_remote = 1'b0;
        end else if (cmd_v && sw_s) begin
          set_refused = 1'b1;
        end else if (cmd_v) begin
          unique case (pwdata[1:0])
            CMD_RUN: begin
              if (state_ff != ST_RUN) begin
                nxt_state = ST_RUN_ENT;
                nxt_remote = 1'b1;
              end
            end
            CMD_STOP: begin
              if (state_ff != ST_STOP) begin
                nxt_state = ST_STOP_ENT;
                nxt_remote = 1'b1;
              end
            end
            CMD_DBG: begin
              if (state_ff == ST_STOP) begin
                nxt_state = ST_DBG_ENT;
                nxt_remote = 1'b1;
              end else if (state_ff != ST_DBG) begin
                set_refused = 1'b1;
              end
            end
            default: begin
              set_refused = 1'b0;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_STOP_ENT;
      remote_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      remote_ff <= nxt_remote;
    end
  end

  // ==========================================================
  // Mode outputs: entry pulses lag the entry state by one cycle
  logic [1:0] mode_ff;
  logic data_init_ff;
  logic out_clear_ff;
  logic out_refresh_ff;
  logic in_refresh_ff;
  logic exec_en_ff;
  logic debug_en_ff;
  logic svc_en_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= MODE_STOP;
      data_init_ff <= 1'b0;
      out_clear_ff <= 1'b0;
      out_refresh_ff <= 1'b0;
      in_refresh_ff <= 1'b0;
      exec_en_ff <= 1'b0;
      debug_en_ff <= 1'b0;
      svc_en_ff <= 1'b0;
    end else if (ce) begin
      mode_ff <= (state_ff inside {ST_RUN_ENT, ST_RUN}) ? MODE_RUN :
        (state_ff inside {ST_DBG_ENT, ST_DBG}) ? MODE_DBG : MODE_STOP;
      data_init_ff <= state_ff inside {ST_RUN_ENT, ST_DBG_ENT};
      out_clear_ff <= state_ff inside {ST_STOP_ENT, ST_DBG_ENT};
      out_refresh_ff <= (state_ff == ST_STOP_ENT)
        || (state_ff == ST_DBG && dbg_prog_end);
      in_refresh_ff <= (state_ff == ST_DBG_ENT);
      exec_en_ff <= run;
      debug_en_ff <= (state_ff == ST_DBG);
      svc_en_ff <= state_ff inside {ST_STOP, ST_RUN, ST_DBG};
    end
  end

  assign mode = mode_ff;
  assign data_init = data_init_ff;
  assign out_clear = out_clear_ff;
  assign out_refresh = out_refresh_ff;
  assign in_refresh = in_refresh_ff;
  assign exec_en = exec_en_ff;
  assign debug_en = debug_en_ff;
  assign svc_en = svc_en_ff;

  // ==========================================================
  // End-of-scan walk over the trigger slots
  function automatic logic f_hit(input logic is_word, input logic [2:0] cond,
      input logic bit_now, input logic bit_prev, input logic [15:0] w,
      input logic [15:0] cmp);
    logic r;
    r = 1'b0;
    if (is_word) begin
      unique case (cond)
        C_LT: r = (w < cmp);
        C_LE: r = (w <= cmp);
        C_EQ: r = (w == cmp);
        C_GE: r = (w >= cmp);
        C_GT: r = (w > cmp);
        default: r = 1'b0;
      endcase
    end else begin
      unique case (cond)
        C_RISE: r = bit_now & ~bit_prev;
        C_FALL: r = ~bit_now & bit_prev;
        C_TRANS: r = bit_now ^ bit_prev;
        C_ON: r = bit_now;
        C_OFF: r = ~bit_now;
        default: r = 1'b0;
      endcase
    end
    return r;
  endfunction : f_hit

  ttmc_walk_t w_ff;
  logic [3:0] idx_ff;
  logic [31:0] src_ff;
  logic [11:0] dev_addr_ff;
  logic [NSLOT-1:0] prev_ff;
  logic mem_re;
  logic [3:0] mem_raddr;
  logic [31:0] mem_q;
  logic bit_now;
  logic req_int;
  logic last;

  assign last = (idx_ff == 4'hF);
  assign bit_now = dev_rdata[src_ff[3:0]];
  // Only the value at the sample counts; nothing is latched between
  assign req_int = (w_ff == W_EVAL) & en_ff[idx_ff] & run
    & f_hit(word_ff[idx_ff], cond_ff[idx_ff], bit_now, prev_ff[idx_ff],
      dev_rdata, src_ff[31:16]);

  always_comb begin
    mem_re = 1'b0;
    mem_raddr = idx_ff + 4'h1;
    if (w_ff == W_IDLE && scan_end && run) begin
      mem_re = 1'b1;
      mem_raddr = 4'h0;
    end else if (w_ff == W_EVAL && !last) begin
      mem_re = 1'b1;
    end
  end

  ttmc_mem #(.DW(32), .DEPTH(NSLOT), .AW(4)) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .we(wr_src),
    .waddr(sel_ff),
    .wdata(pwdata),
    .re(mem_re),
    .raddr(mem_raddr),
    .rdata(mem_q)
  );

  // A scan end that arrives while a walk is in progress is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_ff <= W_IDLE;
      idx_ff <= 4'h0;
      src_ff <= '0;
      dev_addr_ff <= '0;
      prev_ff <= '0;
    end else if (ce) begin
      if (!run) begin
        w_ff <= W_IDLE;
      end else begin
        unique case (w_ff)
          W_IDLE: begin
            if (scan_end) begin
              w_ff <= W_SRC;
              idx_ff <= 4'h0;
            end
          end
          W_SRC: begin
            src_ff <= mem_q;
            dev_addr_ff <= mem_q[15:4];
            w_ff <= W_WAIT;
          end
          W_WAIT: begin
            w_ff <= W_EVAL;
          end
          W_EVAL: begin
            prev_ff[idx_ff] <= bit_now;
            idx_ff <= idx_ff + 4'h1;
            w_ff <= last ? W_IDLE : W_SRC;
          end
        endcase
      end
    end
  end

  assign dev_addr = dev_addr_ff;

  // ==========================================================
  // Counter-match polling
  logic [PW-1:0] poll_ff;
  logic hsc_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poll_ff <= '0;
    end else if (ce) begin
      if (!run || poll_ff == POLL_LAST) begin
        poll_ff <= '0;
      end else begin
        poll_ff <= poll_ff + PW'(1);
      end
    end
  end

  assign hsc_hit = run && hsc_en_ff && poll_ff == POLL_LAST
    && int'(hsc_ch_ff) < NCH
    && hsc_count[int'(hsc_ch_ff) * 32 +: 32]
       == hsc_cmp0[int'(hsc_ch_ff) * 32 +: 32];

  // ==========================================================
  // Pending, running and arbitration
  logic [NALL-1:0] pend_ff;
  logic [NALL-1:0] run_ff;
  logic [NALL-1:0] set_v;
  logic [NALL-1:0] take_v;
  logic [NALL-1:0] done_v;
  logic [2:0] all_prio [NALL];
  logic [5:0] all_num [NALL];
  logic found;
  logic [2:0] best;
  logic [4:0] win;
  logic req_valid_ff;
  logic [5:0] req_num_ff;
  logic [2:0] req_prio_ff;
  logic [4:0] req_slot_ff;
  logic take;

  assign take = req_valid_ff & task_ready;

  always_comb begin
    set_v = '0;
    set_v[idx_ff] = req_int;
    set_v[NSLOT] = hsc_hit;
    take_v = '0;
    take_v[req_slot_ff] = take;
    for (int i = 0; i < NALL; i++) begin
      all_prio[i] = (i < NSLOT) ? prio_ff[i] : hsc_prio_ff;
      all_num[i] = (i < NSLOT) ? num_ff[i] : hsc_num_ff;
      done_v[i] = task_done && run_ff[i] && all_num[i] == task_done_num;
    end
    found = 1'b0;
    best = 3'h7;
    win = 5'h00;
    // Lower value wins, ties go to the lower slot
    for (int i = 0; i < NALL; i++) begin
      if (pend_ff[i] && (!found || all_prio[i] < best)) begin
        found = 1'b1;
        best = all_prio[i];
        win = 5'(i);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= '0;
      run_ff <= '0;
    end else if (ce) begin
      if (run) begin
        pend_ff <= (pend_ff & ~take_v) | (set_v & ~pend_ff & ~run_ff);
      end else begin
        pend_ff <= '0;
      end
      run_ff <= (run_ff & ~done_v) | take_v;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_valid_ff <= 1'b0;
      req_num_ff <= 6'h00;
      req_prio_ff <= 3'h0;
      req_slot_ff <= 5'h00;
    end else if (ce) begin
      req_valid_ff <= found & run & ~take;
      req_num_ff <= all_num[win];
      req_prio_ff <= best;
      req_slot_ff <= win;
    end
  end

  assign task_req_valid = req_valid_ff;
  assign task_req_num = req_num_ff;
  assign task_req_prio = req_prio_ff;

  // ==========================================================
  // Sticky status flags: a set in the clearing cycle wins
  logic refused_ff;
  logic cfg_err_ff;
  logic prog_err_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_ff <= 1'b0;
      cfg_err_ff <= 1'b0;
      prog_err_ff <= 1'b0;
    end else if (ce) begin
      refused_ff <= set_refused
        | (refused_ff & ~(wr_stat & pwdata[S_REFUSED]));
      cfg_err_ff <= (wr_cfg & ~cfg_ok)
        | (cfg_err_ff & ~(wr_stat & pwdata[S_CFG_ERR]));
      prog_err_ff <= set_prog_err
        | (prog_err_ff & ~(wr_stat & pwdata[S_PROG_ERR]));
    end
  end

  // ==========================================================
  // Read data, captured in the setup cycle
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      A_STAT: rd_val = {24'h0, (w_ff != W_IDLE), prog_err_ff, cfg_err_ff,
        refused_ff, sw_s, remote_ff, mode_ff};
      A_SEL: rd_val = {28'h0, sel_ff};
      A_CFG: rd_val = {18'h0, cond_ff[sel_ff], word_ff[sel_ff],
        num_ff[sel_ff], prio_ff[sel_ff], en_ff[sel_ff]};
      A_HSC: rd_val = {20'h0, hsc_ch_ff, hsc_num_ff, hsc_prio_ff, hsc_en_ff};
      A_PEND: rd_val = {15'h0, pend_ff};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      prdata_ff <= rd_val;
    end
  end

endmodule : ttmc_top

// ### bench/ttmc_top_asserts.sv
/* Mode and task request checks on ttmc_top ports.
   Bound to the top from the bench; one clock, async reset. */
`timescale 1ns/1ps
module ttmc_top_asserts
  import ttmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] mode,
  input wire logic data_init,
  input wire logic out_clear,
  input wire logic out_refresh,
  input wire logic in_refresh,
  input wire logic exec_en,
  input wire logic debug_en,
  input wire logic task_req_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // Entry steps
  sequence s_init; ##[0:3] data_init; endsequence
  sequence s_clr; ##[0:3] out_clear; endsequence
  chk_mode_three: assert property
    (mode != 2'h3) else $error("bad mode");
  chk_run_init: assert property
    ($changed(mode) && mode == MODE_RUN |-> s_init) else $error("no init");
  chk_stop_clear: assert property
    ($changed(mode) && mode == MODE_STOP |-> s_clr) else $error("no clear");
  chk_dbg_src: assert property
    ($changed(mode) && mode == MODE_DBG |-> $past(mode) == MODE_STOP)
    else $error("debug source");
  chk_dbg_init: assert property
    ($changed(mode) && mode == MODE_DBG |-> s_init) else $error("no init");
  chk_req_run: assert property
    ($rose(task_req_valid) |-> mode == MODE_RUN) else $error("req mode");
  chk_exec_run: assert property
    ($rose(exec_en) |-> mode == MODE_RUN) else $error("exec mode");
  chk_dbg_mode: assert property
    ($rose(debug_en) |-> mode == MODE_DBG) else $error("debug mode");
  chk_stop_idle: assert property
    (mode == MODE_STOP [*3] |-> !exec_en) else $error("exec in stop");
  chk_stop_refresh: assert property
    ($changed(mode) && mode == MODE_STOP |-> out_refresh)
    else $error("no refresh");
  chk_dbg_inref: assert property
    ($changed(mode) && mode == MODE_DBG |-> in_refresh)
    else $error("no in refresh");
endmodule : ttmc_top_asserts

// ### bench/ttmc_exec_model.sv
/* Scan executor model: device word read and task acceptance.
   Assumes word address 1 holds the watched word. */
`timescale 1ns/1ps
module ttmc_exec_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [15:0] word,
  input wire logic [11:0] dev_addr,
  output logic [15:0] dev_rdata,
  input wire logic task_req_valid,
  input wire logic [5:0] task_req_num,
  output logic task_ready,
  output logic task_done,
  output logic [5:0] task_done_num
);
  logic [2:0] cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_rdata <= 16'h0;
      cnt_ff <= 3'h0;
      task_ready <= 1'b0;
      task_done <= 1'b0;
      task_done_num <= 6'h0;
    end else begin
      // Other addresses churn so a stale read never matches
      dev_rdata <= (dev_addr == 12'h001) ? word : ~dev_rdata;
      cnt_ff <= cnt_ff + 3'h1;
      task_ready <= !slow || cnt_ff[2];
      task_done <= task_req_valid && task_ready;
      task_done_num <= task_req_num;
    end
  end
endmodule : ttmc_exec_model

// ### bench/test_task_trigger_mode_controller.sv
/* Self-checking bench of ttmc_top over APB.
   Assumes the executor model and a short counter poll. */
`timescale 1ns/1ps
module test_task_trigger_mode_controller;
  import ttmc_pkg::*;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, sw_run_pin = 0, prog_valid = 1, scan_end = 0;
  logic dbg_prog_end = 0, slow = 1, task_req_valid, task_ready, task_done;
  logic [11:0] dev_addr;
  logic [15:0] dev_rdata, word = 16'h00A4;
  logic [63:0] hsc_count = 64'h0, hsc_cmp0 = 64'h5;
  logic [5:0] task_req_num, task_done_num;
  logic [2:0] task_req_prio;
  logic [1:0] mode;
  logic data_init, out_clear, out_refresh, in_refresh, exec_en, debug_en;
  logic svc_en;
  int fail_count = 0, n_checks = 0, n_take = 0;
  always #5 pclk = ~pclk;
  // Counts every take, so a short-lived request cannot slip past a check
  always @(posedge pclk) begin
    if (task_req_valid === 1'b1 && task_ready === 1'b1) n_take <= n_take + 1;
  end
  ttmc_top #(.HSC_POLL(50)) u_dut (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sw_run_pin,
    .prog_valid, .scan_end, .dbg_prog_end, .dev_addr, .dev_rdata,
    .hsc_count, .hsc_cmp0, .task_req_valid, .task_req_num, .task_req_prio,
    .task_ready, .task_done, .task_done_num, .mode, .data_init, .out_clear,
    .out_refresh, .in_refresh, .exec_en, .debug_en, .svc_en);
  ttmc_exec_model u_exec (.pclk, .presetn, .slow, .word, .dev_addr,
    .dev_rdata, .task_req_valid, .task_req_num, .task_ready, .task_done,
    .task_done_num);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // ==========
  // APB master: holds the request until pready, then idles one cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rdv = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic st(input int b, input logic e);
    apb(0, A_STAT, 32'h0);
    chk(rdv[b], e);
    apb(1, A_STAT, 32'h70);
  endtask : st
  // Waits for the take edge and judges the request standing there
  task automatic wreq(input logic [5:0] num, input logic [2:0] pr);
    do @(posedge pclk);
    while (task_req_valid !== 1'b1 || task_ready !== 1'b1);
    chk(task_req_num, num);
    chk(task_req_prio, pr);
    @(posedge pclk);
  endtask : wreq
  task automatic t_cfg;
    apb(1, A_SEL, 32'h0);
    apb(1, A_CFG, 32'h175);
    st(S_CFG_ERR, 1);
    apb(1, A_CFG, 32'h183);
    st(S_CFG_ERR, 1);
    apb(1, A_CFG, 32'h185);
    apb(1, A_SRC, 32'h10);
    apb(1, A_SEL, 32'h1);
    apb(1, A_CFG, 32'h185);
    st(S_CFG_ERR, 1);
    apb(1, A_CFG, 32'h1595);
    apb(1, A_SRC, 32'h00A5_0010);
    st(S_CFG_ERR, 0);
  endtask : t_cfg
  task automatic t_mode;
    sw_run_pin <= 1;
    repeat (12) @(posedge pclk);
    chk(mode, MODE_RUN);
    chk(exec_en, 1);
    apb(1, A_CTRL, 32'h2);
    chk(mode, MODE_RUN);
    st(S_REFUSED, 1);
    sw_run_pin <= 0;
    repeat (12) @(posedge pclk);
    chk(mode, MODE_STOP);
    chk(svc_en, 1);
    apb(1, A_CTRL, 32'h3);
    repeat (8) @(posedge pclk);
    chk(mode, MODE_DBG);
    chk(debug_en, 1);
    dbg_prog_end <= 1;
    @(posedge pclk);
    dbg_prog_end <= 0;
    @(posedge pclk);
    chk(out_refresh, 1);
    apb(1, A_CTRL, 32'h2);
    // Bad program at RUN entry falls back to STOP
    prog_valid <= 0;
    apb(1, A_CTRL, 32'h1);
    st(S_PROG_ERR, 1);
    chk(mode, MODE_STOP);
    prog_valid <= 1;
    apb(1, A_CTRL, 32'h1);
    repeat (8) @(posedge pclk);
    chk(mode, MODE_RUN);
    apb(1, A_CTRL, 32'h3);
    st(S_REFUSED, 1);
  endtask : t_mode
  // Word is set with the scan end, well before the walk reads it
  task automatic scan_at(input logic [15:0] v, input int n);
    word <= v;
    scan_end <= 1;
    @(posedge pclk);
    scan_end <= 0;
    repeat (n) @(posedge pclk);
  endtask : scan_at
  task automatic t_scan;
    scan_at(16'h00A4, 60);
    word <= 16'h00A5;
    repeat (100) @(posedge pclk);
    chk(task_req_valid, 0);
    chk(n_take, 0);
    scan_at(16'h00A4, 60);
    chk(n_take, 0);
    scan_at(16'h00A5, 0);
    wreq(6'h18, 3'h2);
    wreq(6'h19, 3'h2);
  endtask : t_scan
  task automatic t_hsc;
    apb(1, A_CTRL, 32'h2);
    apb(1, A_HSC, 32'h1E7);
    hsc_count <= 64'h5;
    repeat (150) @(posedge pclk);
    chk(task_req_valid, 0);
    chk(n_take, 2);
    apb(1, A_CTRL, 32'h1);
    wreq(6'h1E, 3'h3);
  endtask : t_hsc
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
    chk(mode, MODE_STOP);
    t_cfg();
    t_mode();
    t_scan();
    t_hsc();
    test_done();
  end
  // Generous span: the sequence needs well under 5000 cycles
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
endmodule : test_task_trigger_mode_controller
bind ttmc_top ttmc_top_asserts u_chk (.pclk, .presetn, .mode, .data_init,
  .out_clear, .exec_en, .debug_en, .task_req_valid, .in_refresh,
  .out_refresh);
